// ==== hdl/mtss_bridge.sv ====
// Purpose : Slot addressed selection logic of a multidrop scan bridge
// Assumes : Backplane test clock far slower than ref_clk_i
// Notes   : Backplane pins are sampled; tck edges are found by sampling
//
// Function
// [R1] Master shifts address through Shift/Update-IR
// [R2] Update-IR match selects, mismatch unselects
// [R3] Capture-IR loads 01 and slot inputs
// [R4] Selected bridge shifts capture out serially
// [R5] Master reads back slot; all ones absent
// [R6] Return-to-wait sends controller to wait; a waiting controller takes it as a mismatched address and goes unselected
// [R7] Master polls every address, skips empty
// [R8] Mode select scans mode register; 07 series
// [R9] Attach inserts enabled local ports
// [R10] Return-to-wait also resets local ports
// [R11] Park forces local test mode high
// [R12] Broadcast 3B selects all; reinit parks
// [R13] Unselected bridge never drives backplane out
`timescale 1ns/1ps
`default_nettype none
module mtss_bridge (
   input  wire logic        ref_clk_i,              // 100 MHz clock
   input  wire logic        resetn_i,               // Async reset, low
   input  wire logic        bp_tck_i,               // Backplane test clock
   input  wire logic        bp_tms_i,               // Backplane mode
   input  wire logic        backplane_serial_in_i,  // Backplane data in
   input  wire logic        bp_trst_n_i,            // Test reset, low
   input  wire logic [5:0]  slot_id_inputs_i,       // Slot strap pins
   input  wire logic [2:0]  local_serial_ret_i,     // Local chain returns
   output logic             bp_tdo_o,               // Backplane data out
   output logic             bp_tdo_oe_n_o,          // Data out enable, low
   output mtss_pkg::mtss_lsp_type [2:0] local_scan_port_o, // Local ports
   output logic             selected_o              // Bridge selected
);
   localparam int SW = mtss_pkg::SLOT_W;
   localparam int IW = mtss_pkg::IR_W;
   localparam int NP = mtss_pkg::LSP_N;

   // ==========================================================
   // Pin sampling and clock edge detection
   logic [SW-1:0] slot_s;
   logic [NP-1:0] ret_s;
   logic          tck_s, tms_s, tdi_s, trst_n_s, tck_d_r;
   logic          tck_rise, tck_fall;

   mtss_sync #(.WIDTH(4), .RST_VAL(4'h9)) u_sync_bp (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .async_i   ({bp_trst_n_i, bp_tck_i, bp_tms_i,
                   backplane_serial_in_i}),
      .sync_o    ({trst_n_s, tck_s, tms_s, tdi_s})
   );

   mtss_sync #(.WIDTH(SW + NP), .RST_VAL('0)) u_sync_misc (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .async_i   ({slot_id_inputs_i, local_serial_ret_i}),
      .sync_o    ({slot_s, ret_s})
   );

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tck_d_r <= 1'b0;
      end else begin
         tck_d_r <= tck_s;
      end
   end

   assign tck_rise = tck_s & ~tck_d_r;
   assign tck_fall = ~tck_s & tck_d_r;

   // ==========================================================
   // Backplane TAP controller
   mtss_pkg::mtss_tap_type tap_r;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tap_r <= mtss_pkg::TLR;
      end else if (!trst_n_s) begin
         tap_r <= mtss_pkg::TLR;
      end else if (tck_rise) begin
         tap_r <= mtss_pkg::mtss_tap_next(tap_r, tms_s);
      end
   end

   // ==========================================================
   // Selection controller and instruction register
   mtss_pkg::mtss_sel_type sel_r;
   logic [IW-1:0] ir_sh_r, ir_r, mode_r, mode_sh_r;
   logic          park_r, bypass_r, active, attached, chain_out;
   logic          upd_ir, upd_dr, tlr;

   assign tlr      = (tap_r == mtss_pkg::TLR);
   assign upd_ir   = tck_fall && (tap_r == mtss_pkg::UPD_IR);
   assign upd_dr   = tck_fall && (tap_r == mtss_pkg::UPD_DR);
   assign active   = (sel_r == mtss_pkg::SC_SELECTED) ||
                     (sel_r == mtss_pkg::SC_BCAST);
   assign attached = active && !park_r;
   assign selected_o = active;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ir_sh_r <= mtss_pkg::OP_BYPASS;
      end else if (tck_rise && tap_r == mtss_pkg::CAP_IR) begin
         // [R3] Capture slot id
         ir_sh_r <= {slot_s, mtss_pkg::IR_CAPTURE_LSB};
      end else if (tck_rise && tap_r == mtss_pkg::SHF_IR) begin
         // [R4] Shift out, shift in
         ir_sh_r <= {chain_out, ir_sh_r[IW-1:1]};
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sel_r <= mtss_pkg::SC_WAIT;
         ir_r  <= mtss_pkg::OP_BYPASS;
      end else if (tlr) begin
         sel_r <= mtss_pkg::SC_WAIT;
         ir_r  <= mtss_pkg::OP_BYPASS;
      end else if (upd_ir) begin
         case (sel_r)
            mtss_pkg::SC_WAIT: begin
               // [R12] Broadcast selects all
               if (ir_sh_r == mtss_pkg::BROADCAST_ADDR) begin
                  sel_r <= mtss_pkg::SC_BCAST;
               // [R2] Address compare
               end else if (ir_sh_r == {mtss_pkg::ADDR_PAD, slot_s}) begin
                  sel_r <= mtss_pkg::SC_SELECTED;
               end else begin
                  sel_r <= mtss_pkg::SC_UNSEL;
               end
               ir_r <= mtss_pkg::OP_BYPASS;
            end
            default: begin
               // [R6] Every non-waiting bridge back to wait
               if (ir_sh_r == mtss_pkg::OP_RETURN_WAIT) begin
                  sel_r <= mtss_pkg::SC_WAIT;
                  ir_r  <= mtss_pkg::OP_BYPASS;
               end else if (active) begin
                  ir_r <= ir_sh_r;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Local port park control
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         park_r <= 1'b1;
      end else if (tlr) begin
         park_r <= 1'b1;
      end else if (upd_ir && sel_r != mtss_pkg::SC_WAIT) begin
         // [R10] Return-to-wait resets ports
         if (ir_sh_r == mtss_pkg::OP_RETURN_WAIT) begin
            park_r <= 1'b1;
         end else if (active) begin
            // [R11] Park in reset
            if (ir_sh_r == mtss_pkg::OP_PARK_RESET ||
                // [R12] Reinit all ports
                ir_sh_r == mtss_pkg::OP_REINIT_ALL) begin
               park_r <= 1'b1;
            // [R9] Attach local chains
            end else if (ir_sh_r == mtss_pkg::OP_ATTACH) begin
               park_r <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // Data registers: mode and bypass
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_sh_r <= mtss_pkg::MODE_RESET;
         bypass_r  <= 1'b0;
      end else if (tck_rise && tap_r == mtss_pkg::CAP_DR) begin
         mode_sh_r <= mode_r;
         bypass_r  <= 1'b0;
      end else if (tck_rise && tap_r == mtss_pkg::SHF_DR) begin
         mode_sh_r <= {chain_out, mode_sh_r[IW-1:1]};
         bypass_r  <= chain_out;
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_r <= mtss_pkg::MODE_RESET;
      end else if (tlr) begin
         mode_r <= mtss_pkg::MODE_RESET;
      // [R8] Mode register load
      end else if (upd_dr && active && ir_r == mtss_pkg::OP_MODE_SEL) begin
         mode_r <= mode_sh_r;
      end
   end

   // ==========================================================
   // Local chain routing, backplane data first through enabled ports
   logic [NP-1:0] port_en;
   logic [NP-1:0] port_tdi;

   // [R9] Enabled ports in series
   assign port_en = attached ? mode_r[NP-1:0] : '0;

   always_comb begin
      logic feed;
      feed     = tdi_s;
      port_tdi = '0;
      for (int k = 0; k < NP; k++) begin
         port_tdi[k] = feed;
         if (port_en[k]) begin
            feed = ret_s[k];
         end
      end
      chain_out = feed;
   end

   // Local clocks run always so parked TAPs still walk to reset
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int k = 0; k < NP; k++) begin
            local_scan_port_o[k] <= '{1'b0, 1'b1, 1'b1};
         end
      end else begin
         for (int k = 0; k < NP; k++) begin
            local_scan_port_o[k].tck <= tck_s;
            // [R11] Parked ports held high
            local_scan_port_o[k].local_test_mode_out <=
               port_en[k] ? tms_s : 1'b1;
            local_scan_port_o[k].tdi <= port_tdi[k];
         end
      end
   end

   // ==========================================================
   // Backplane data out, changes on falling test clock
   logic own_out;
   logic shifting;

   assign shifting = (tap_r == mtss_pkg::SHF_IR) ||
                     (tap_r == mtss_pkg::SHF_DR);

   always_comb begin
      if (tap_r == mtss_pkg::SHF_IR) begin
         own_out = ir_sh_r[0];
      end else if (ir_r == mtss_pkg::OP_MODE_SEL) begin
         own_out = mode_sh_r[0];
      end else begin
         own_out = bypass_r;
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bp_tdo_o      <= 1'b1;
         bp_tdo_oe_n_o <= 1'b1;
      end else if (tck_fall) begin
         // [R4] Serial read-back
         bp_tdo_o      <= own_out;
         // [R13] Only the addressed bridge drives
         bp_tdo_oe_n_o <= !(shifting && sel_r == mtss_pkg::SC_SELECTED);
      end
   end

endmodule : mtss_bridge
`default_nettype wire

// ==== hdl/mtss_pkg.sv ====
// Purpose : Shared constants and types of the multidrop slot select bridge
// Assumes : Eight bit instruction register, six slot inputs, three ports
// Notes   : Opcode values other than the broadcast address are local picks
package mtss_pkg;

   // ==========================================================
   // Widths
   localparam int IR_W    = 8;
   localparam int SLOT_W  = 6;
   localparam int LSP_N   = 3;

   // ==========================================================
   // Instruction register values
   localparam logic [1:0]      IR_CAPTURE_LSB = 2'h1;
   localparam logic [1:0]      ADDR_PAD       = 2'h0;
   localparam logic [IR_W-1:0] BROADCAST_ADDR = 8'h3B;
   localparam logic [IR_W-1:0] OP_BYPASS      = 8'hFF;
   localparam logic [IR_W-1:0] OP_RETURN_WAIT = 8'hC1;
   localparam logic [IR_W-1:0] OP_MODE_SEL    = 8'hC2;
   localparam logic [IR_W-1:0] OP_ATTACH      = 8'hC3;
   localparam logic [IR_W-1:0] OP_PARK_RESET  = 8'hC4;
   localparam logic [IR_W-1:0] OP_REINIT_ALL  = 8'hC5;

   // ==========================================================
   // Mode register
   localparam logic [IR_W-1:0] MODE_RESET     = 8'h00;
   localparam logic [IR_W-1:0] MODE_ALL_SER   = 8'h07;

   // ==========================================================
   // Types
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
   } mtss_tap_type;

   typedef enum logic [1:0] {
      SC_WAIT, SC_SELECTED, SC_BCAST, SC_UNSEL
   } mtss_sel_type;

   typedef struct packed {
      logic tck;
      logic local_test_mode_out;
      logic tdi;
   } mtss_lsp_type;

   // ==========================================================
   // Standard test access port state walk
   function automatic mtss_tap_type mtss_tap_next(input mtss_tap_type s,
                                                  input logic tms);
      mtss_tap_type n;
      n = TLR;
      case (s)
         TLR:     n = tms ? TLR    : RTI;
         RTI:     n = tms ? SEL_DR : RTI;
         SEL_DR:  n = tms ? SEL_IR : CAP_DR;
         CAP_DR:  n = tms ? EX1_DR : SHF_DR;
         SHF_DR:  n = tms ? EX1_DR : SHF_DR;
         EX1_DR:  n = tms ? UPD_DR : PAU_DR;
         PAU_DR:  n = tms ? EX2_DR : PAU_DR;
         EX2_DR:  n = tms ? UPD_DR : SHF_DR;
         UPD_DR:  n = tms ? SEL_DR : RTI;
         SEL_IR:  n = tms ? TLR    : CAP_IR;
         CAP_IR:  n = tms ? EX1_IR : SHF_IR;
         SHF_IR:  n = tms ? EX1_IR : SHF_IR;
         EX1_IR:  n = tms ? UPD_IR : PAU_IR;
         PAU_IR:  n = tms ? EX2_IR : PAU_IR;
         EX2_IR:  n = tms ? UPD_IR : SHF_IR;
         UPD_IR:  n = tms ? SEL_DR : RTI;
         default: n = TLR;
      endcase
      return n;
   endfunction : mtss_tap_next

endpackage : mtss_pkg

// ==== hdl/mtss_sync.sv ====
// Purpose : Two flip-flop synchroniser for pin inputs
// Assumes : Each bit is an independent level
// Notes   : First stage is read by the second stage only
`timescale 1ns/1ps
`default_nettype none
module mtss_sync #(
   parameter int          WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             ref_clk_i,  // System clock
   input  wire logic             resetn_i,   // Async reset, active low
   input  wire logic [WIDTH-1:0] async_i,    // Pin levels
   output logic      [WIDTH-1:0] sync_o      // Synchronised levels
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta_r <= RST_VAL;
         sync_o <= RST_VAL;
      end else begin
         meta_r <= async_i;
         sync_o <= meta_r;
      end
   end
endmodule : mtss_sync
`default_nettype wire

// ==== tb/mtss_bridge_assertions.sv ====
// Purpose : Port checks of the slot select bridge
// Assumes : Backplane test clock far slower than ref_clk_i
// Notes   : Windows allow for the pin sampling delay
`timescale 1ns/1ps
`default_nettype none
module mtss_bridge_assertions (
   input wire logic       ref_clk_i,       // Clock
   input wire logic       resetn_i,        // Reset, low
   input wire logic       bp_tck_i,        // Test clock pin
   input wire logic       bp_tms_i,        // Test mode pin
   input wire logic       bp_tdo_o,        // Data out
   input wire logic       bp_tdo_oe_n_o,   // Drive enable, low
   input wire mtss_pkg::mtss_lsp_type [2:0] local_scan_port_o, // Ports
   input wire logic       selected_o       // Selected
);
   // ==========================================================
   // Checks
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   logic [3:0] fall_cnt_r;
   logic [2:0] mode_out;
   assign mode_out = {local_scan_port_o[2].local_test_mode_out,
                      local_scan_port_o[1].local_test_mode_out,
                      local_scan_port_o[0].local_test_mode_out};
   // Cycles since the last test clock fall, saturating
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fall_cnt_r <= 4'hF;
      end else if ($fell(bp_tck_i)) begin
         fall_cnt_r <= 4'h0;
      end else if (fall_cnt_r != 4'hF) begin
         fall_cnt_r <= fall_cnt_r + 4'h1;
      end
   end
   property p_unsel_quiet;
      !selected_o |-> bp_tdo_oe_n_o;
   endproperty
   a_unsel_quiet: assert property (p_unsel_quiet)
      else $error("data out driven while unselected");
   property p_drive_hold;
      $fell(bp_tdo_oe_n_o) |-> !bp_tdo_oe_n_o [*8];
   endproperty
   a_drive_hold: assert property (p_drive_hold)
      else $error("drive enable dropped too soon");
   property p_tdo_late;
      $changed(bp_tdo_o) && !bp_tdo_oe_n_o |-> fall_cnt_r <= 4'h6;
   endproperty
   a_tdo_late: assert property (p_tdo_late)
      else $error("data out moved away from a clock fall");
   property p_oe_late;
      $changed(bp_tdo_oe_n_o) |-> fall_cnt_r <= 4'h6;
   endproperty
   a_oe_late: assert property (p_oe_late)
      else $error("drive enable moved away from a clock fall");
   // Only a selection is tied to a clock fall; a test logic reset may
   // drop it on a rising test clock
   property p_sel_late;
      $rose(selected_o) |-> fall_cnt_r <= 4'h6;
   endproperty
   a_sel_late: assert property (p_sel_late)
      else $error("selection moved away from a clock fall");
   property p_desel_park;
      $fell(selected_o) |-> ##[0:8] (mode_out == 3'h7);
   endproperty
   a_desel_park: assert property (p_desel_park)
      else $error("local ports not reset on deselect");
   property p_tck_follow;
      $rose(bp_tck_i) |-> ##[2:6] (local_scan_port_o[0].tck
         && local_scan_port_o[1].tck && local_scan_port_o[2].tck);
   endproperty
   a_tck_follow: assert property (p_tck_follow)
      else $error("local clock does not follow");
   property p_tms_pass;
      $rose(bp_tms_i) |-> ##[3:6] (mode_out == 3'h7);
   endproperty
   a_tms_pass: assert property (p_tms_pass)
      else $error("local mode out below backplane mode");
   c_sel: cover property ($rose(selected_o));
   c_drive: cover property ($fell(bp_tdo_oe_n_o));
   c_desel: cover property ($fell(selected_o));
endmodule : mtss_bridge_assertions
bind mtss_bridge mtss_bridge_assertions mtss_bridge_assertions_inst (
   .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .bp_tck_i(bp_tck_i),
   .bp_tms_i(bp_tms_i), .bp_tdo_o(bp_tdo_o),
   .bp_tdo_oe_n_o(bp_tdo_oe_n_o), .local_scan_port_o(local_scan_port_o),
   .selected_o(selected_o));
`default_nettype wire

// ==== tb/mtss_master_model.sv ====
// Purpose : Backplane test master model
// Assumes : Bridge tap rests in run-test/idle between frames
// Notes   : Test clock stands low outside frames
`timescale 1ns/1ps
`default_nettype none
module mtss_master_model (
   output logic      tck_o,     // Test clock
   output logic      tms_o,     // Test mode
   output logic      tdi_o,     // Data to bridge
   output logic      trst_n_o,  // Test reset, low
   input  wire logic tdo_i,     // Data from bridge
   input  wire logic oe_n_i     // Bridge drives, low
);
   // ==========================================================
   // Frames
   logic line;
   assign line = oe_n_i ? 1'b1 : tdo_i;
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
      trst_n_o = 1'b0;
      #400 trst_n_o = 1'b1;
   end
   task automatic tick(input logic m, input logic d, output logic q);
      tms_o = m;
      tdi_o = d;
      #62.5 q = line;
      tck_o = 1'b1;
      #62.5 tck_o = 1'b0;
   endtask : tick
   task automatic idle();
      logic q;
      #3 tick(1'b0, 1'b1, q);
   endtask : idle
   // shift then update
   // Pad bits push the value through attached local cells ahead of the
   // bridge register, so the bridge still ends up holding v
   task automatic scan(input logic ir, input logic [7:0] v, input int pad,
                       output logic [7:0] cap);
      logic q;
      #3 tick(1'b1, 1'b1, q);
      if (ir) tick(1'b1, 1'b1, q);
      tick(1'b0, 1'b1, q);
      tick(1'b0, 1'b1, q);
      for (int i = 0; i < 8 + pad; i++) begin
         tick(i == 7 + pad, (i < 8) ? v[i] : 1'b1, q);
         if (i < 8) begin
            cap[i] = q;
         end
      end
      tick(1'b1, 1'b1, q);
      tick(1'b0, 1'b1, q);
   endtask : scan
endmodule : mtss_master_model
`default_nettype wire

// ==== tb/mtss_bridge_tb_top.sv ====
// Purpose : Self-checking bench of the slot select bridge
// Assumes : Partner model drives the backplane pins
// Notes   : Each local chain is a single cell on the port 0 local test clock
`timescale 1ns/1ps
`default_nettype none
module mtss_bridge_tb_top;
   // ==========================================================
   // Harness
   logic       ref_clk_i = 1'b0;
   logic       resetn_i  = 1'b0;
   logic [5:0] slot      = 6'h15;
   logic       tck, tms, tdi, trst_n, tdo, oe_n, sel;
   logic [2:0] ret       = 3'h7;
   logic [2:0] mo;
   int         miscompares = 0;
   int         n_tests     = 0;
   int         pad         = 0;
   mtss_pkg::mtss_lsp_type [2:0] lsp;
   // A wire loop back cannot settle through three sampled ports within
   // half a test clock; a real chain holds at least one cell per port
   always @(posedge lsp[0].tck) begin
      ret <= {lsp[2].tdi, lsp[1].tdi, lsp[0].tdi};
   end
   assign mo  = {lsp[2].local_test_mode_out, lsp[1].local_test_mode_out,
                 lsp[0].local_test_mode_out};
   always #5 ref_clk_i = ~ref_clk_i;
   mtss_bridge mtss_bridge_inst (
      .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .bp_tck_i(tck),
      .bp_tms_i(tms), .backplane_serial_in_i(tdi), .bp_trst_n_i(trst_n),
      .slot_id_inputs_i(slot), .local_serial_ret_i(ret), .bp_tdo_o(tdo),
      .bp_tdo_oe_n_o(oe_n), .local_scan_port_o(lsp), .selected_o(sel));
   mtss_master_model mtss_master_model_inst (
      .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n),
      .tdo_i(tdo), .oe_n_i(oe_n));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic sc(input logic ir, input logic [7:0] v,
                     output logic [7:0] cap);
      mtss_master_model_inst.scan(ir, v, pad, cap);
      repeat (10) @(negedge ref_clk_i);
   endtask : sc
   task automatic attach_all();
      logic [7:0] c;
      sc(1'b1, mtss_pkg::OP_MODE_SEL, c);
      sc(1'b0, mtss_pkg::MODE_ALL_SER, c);
      chk({5'h00, mo}, 8'h07);
      sc(1'b1, mtss_pkg::OP_ATTACH, c);
      pad = mtss_pkg::LSP_N;
      chk({5'h00, mo}, 8'h00);
   endtask : attach_all
   task automatic t_poll();
      logic [7:0] c;
      logic [7:0] a;
      logic       hit;
      for (int i = 0; i < 3; i++) begin
         a = 8'(24'h145515 >> (8 * i));
         hit = (a == {2'h0, slot});
         sc(1'b1, a, c);
         chk({7'h00, sel}, {7'h00, hit});
         sc(1'b1, mtss_pkg::OP_RETURN_WAIT, c);
         chk(c, hit ? {slot, 2'h1} : 8'hFF);
         chk({7'h00, sel}, 8'h00);
      end
      $display("poll test done");
   endtask : t_poll
   task automatic t_modes();
      logic [7:0] c;
      sc(1'b1, {2'h0, slot}, c);
      attach_all();
      sc(1'b1, mtss_pkg::OP_PARK_RESET, c);
      pad = 0;
      chk({5'h00, mo}, 8'h07);
      sc(1'b1, mtss_pkg::OP_RETURN_WAIT, c);
      chk({7'h00, sel}, 8'h00);
      sc(1'b1, {2'h0, slot}, c);
      attach_all();
      sc(1'b1, mtss_pkg::OP_RETURN_WAIT, c);
      pad = 0;
      chk({4'h0, sel, mo}, 8'h07);
      $display("mode test done");
   endtask : t_modes
   task automatic t_bcast();
      logic [7:0] c;
      slot = 6'h2A;
      sc(1'b1, mtss_pkg::BROADCAST_ADDR, c);
      chk({7'h00, sel}, 8'h01);
      attach_all();
      sc(1'b1, mtss_pkg::OP_REINIT_ALL, c);
      pad = 0;
      chk(c, 8'hFF);
      chk({5'h00, mo}, 8'h07);
      sc(1'b1, mtss_pkg::OP_RETURN_WAIT, c);
      chk({7'h00, sel}, 8'h00);
      $display("broadcast test done");
   endtask : t_bcast
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   initial begin
      repeat (12) @(negedge ref_clk_i);
      chk({3'h0, oe_n, sel, mo}, 8'h17);
      resetn_i = 1'b1;
      repeat (40) @(negedge ref_clk_i);
      mtss_master_model_inst.idle();
      repeat (10) @(negedge ref_clk_i);
      t_poll();
      t_modes();
      t_bcast();
      conclude();
   end
   // Guard against a hung run
   initial begin
      repeat (100000) @(posedge ref_clk_i);
      miscompares++;
      conclude();
   end
endmodule : mtss_bridge_tb_top
`default_nettype wire
